// ==== can_rx_buffer_flags.sv ====
// Receive-buffer full and overflow flags, identifier mask registers and an APB slave.
// Assumes APB signals and receive-write requests are synchronous to sys_clk_in.
// Notes on behaviour
// - Low extended mask bit 1 compares that identifier bit; 0 ignores it.
// - Thirty-two full flags; buffers 0-15 in low register, 16-31 in high.
// - Filling a buffer with a received message sets its full flag.
// - Thirty-two overflow flags split over low and high registers, one bit each.
// - Writing a message to an already full buffer sets its overflow flag.
// - Standard mask bit 1 compares that identifier bit; 0 ignores it.
// - With type-match mode set, message format must equal the filter format select.
`timescale 1ns/1ps
`include "can_rx_consts.svh"
module can_rx_buffer_flags #(
   parameter int NUM_BUFFERS = 32
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic rx_write_in,
   input wire logic [4:0] rx_buffer_in,
   input wire logic [10:0] msg_std_id_in,
   input wire logic [17:0] msg_ext_id_in,
   input wire logic msg_is_ext_in,
   output logic rx_accept_out,
   output logic irq_out
);
   can_rx_pkg::half_word_t ext_id_mask_low_r;
   logic [13:0] std_mask_r;
   logic [31:0] filter_r;
   logic [2:0] irq_status_r;
   logic [2:0] irq_mask_r;
   logic [NUM_BUFFERS-1:0] rx_buffer_full_flag;
   logic [NUM_BUFFERS-1:0] rx_buffer_overflow_flag;
   can_rx_pkg::apb_phase_e phase_r;
   logic [31:0] read_nxt;

   wire access = psel_in && penable_in;
   wire wr = access && pwrite_in;
   wire rd = access && !pwrite_in;
   wire sel_std = paddr_in == `OFS_STD_MASK;
   wire sel_ext_hi = paddr_in == `OFS_EXT_MASK_HIGH;
   wire sel_ext_lo = paddr_in == `OFS_EXT_MASK_LOW;
   wire sel_full_lo = paddr_in == `OFS_FULL_LOW;
   wire sel_full_hi = paddr_in == `OFS_FULL_HIGH;
   wire sel_ovf_lo = paddr_in == `OFS_OVF_LOW;
   wire sel_ovf_hi = paddr_in == `OFS_OVF_HIGH;
   wire sel_irq_st = paddr_in == `OFS_IRQ_STATUS;
   wire sel_irq_mk = paddr_in == `OFS_IRQ_MASK;
   wire sel_filter = paddr_in == `OFS_FILTER;
   wire mapped = sel_std || sel_ext_hi || sel_ext_lo || sel_full_lo || sel_full_hi || sel_ovf_lo || sel_ovf_hi ||
      sel_irq_st || sel_irq_mk || sel_filter;

   // Low-half clear mask: a written 0 requests a clear, a written 1 is ignored.
   function automatic logic [15:0] zero_clears(input logic [31:0] data);
      zero_clears = ~data[15:0];
   endfunction : zero_clears

   wire [NUM_BUFFERS-1:0] full_clear = {
      (wr && sel_full_hi) ? zero_clears(pwdata_in) : 16'h0000,
      (wr && sel_full_lo) ? zero_clears(pwdata_in) : 16'h0000};
   wire [NUM_BUFFERS-1:0] ovf_clear = {
      (wr && sel_ovf_hi) ? zero_clears(pwdata_in) : 16'h0000,
      (wr && sel_ovf_lo) ? zero_clears(pwdata_in) : 16'h0000};

   wire filter_match;
   can_rx_id_filter u_filter (
      .msg_std_id_in(msg_std_id_in),
      .msg_ext_id_in(msg_ext_id_in),
      .msg_is_ext_in(msg_is_ext_in),
      .filt_std_id_in(filter_r[`FILTER_STD_POS +: 11]),
      .filt_ext_id_in(filter_r[`FILTER_EXT_POS +: 16] == 16'h0000 ? 18'h00000 :
         {2'b00, filter_r[`FILTER_EXT_POS +: 16]}),
      .filter_format_select_in(filter_r[`FILTER_FORMAT_POS]),
      .std_id_mask_bits_in(std_mask_r[13:3]),
      .ext_id_mask_bits_in({std_mask_r[1:0], ext_id_mask_low_r}),
      .id_type_match_mode_in(std_mask_r[2]),
      .match_out(filter_match)
   );

   // Only accepted messages are written, so only they touch the flags.
   wire do_write = rx_write_in && filter_match;
   wire [NUM_BUFFERS-1:0] buf_onehot = do_write ? (NUM_BUFFERS'(1) << rx_buffer_in) : '0;
   wire [NUM_BUFFERS-1:0] ovf_set = buf_onehot & rx_buffer_full_flag;

   can_rx_flag_bank #(.NUM_BUFFERS(NUM_BUFFERS)) u_full (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .set_in(buf_onehot),
      .clear_in(full_clear),
      .flags_out(rx_buffer_full_flag)
   );

   can_rx_flag_bank #(.NUM_BUFFERS(NUM_BUFFERS)) u_ovf (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .set_in(ovf_set),
      .clear_in(ovf_clear),
      .flags_out(rx_buffer_overflow_flag)
   );

   wire [2:0] irq_events = {do_write, |ovf_set, do_write & ~|ovf_set};
   wire [2:0] irq_event_bits = {irq_events[2], irq_events[1], irq_events[0]};
   wire irq_status_read = rd && sel_irq_st && phase_r == can_rx_pkg::bus_access;

   always_comb begin
      read_nxt = 32'h00000000;
      if (sel_std) begin
         read_nxt = {16'h0000, std_mask_r[13:3], 1'b0, std_mask_r[2], 1'b0, std_mask_r[1:0]};
      end else if (sel_ext_hi) begin
         read_nxt = {30'h00000000, std_mask_r[1:0]};
      end else if (sel_ext_lo) begin
         read_nxt = {16'h0000, ext_id_mask_low_r};
      end else if (sel_full_lo) begin
         read_nxt = {16'h0000, rx_buffer_full_flag[15:0]};
      end else if (sel_full_hi) begin
         read_nxt = {16'h0000, rx_buffer_full_flag[31:16]};
      end else if (sel_ovf_lo) begin
         read_nxt = {16'h0000, rx_buffer_overflow_flag[15:0]};
      end else if (sel_ovf_hi) begin
         read_nxt = {16'h0000, rx_buffer_overflow_flag[31:16]};
      end else if (sel_irq_st) begin
         read_nxt = {29'h00000000, irq_status_r};
      end else if (sel_irq_mk) begin
         read_nxt = {29'h00000000, irq_mask_r};
      end else if (sel_filter) begin
         read_nxt = filter_r;
      end
   end

   // The slave inserts one wait state so read data and pready both leave flip-flops.
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         phase_r <= can_rx_pkg::bus_idle;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= `CTRL_RESET;
      end else if (access && phase_r == can_rx_pkg::bus_idle) begin
         phase_r <= can_rx_pkg::bus_access;
         pready_out <= 1'b1;
         pslverr_out <= !mapped;
         prdata_out <= pwrite_in ? 32'h00000000 : read_nxt;
      end else begin
         phase_r <= can_rx_pkg::bus_idle;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end
   end

   // Mask, filter and interrupt-mask writes land only at the completing edge of the access; flag clears act on both edges.
   wire commit_wr = wr && phase_r == can_rx_pkg::bus_access;

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         ext_id_mask_low_r <= `MASK_RESET;
         std_mask_r <= 14'h0000;
         filter_r <= `CTRL_RESET;
         irq_mask_r <= `IRQ_RESET;
      end else if (commit_wr) begin
         if (sel_ext_lo) ext_id_mask_low_r <= pwdata_in[15:0];
         if (sel_std) std_mask_r <= {pwdata_in[`STD_MASK_POS +: 11], pwdata_in[`ID_TYPE_MODE_POS],
            pwdata_in[1:0]};
         if (sel_ext_hi) std_mask_r[1:0] <= pwdata_in[`EXT_HIGH_MASK_POS +: 2];
         if (sel_filter) filter_r <= pwdata_in;
         if (sel_irq_mk) irq_mask_r <= pwdata_in[2:0];
      end
   end

   // A new event in the cycle of a clearing read stays set.
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         irq_status_r <= `IRQ_RESET;
         irq_out <= 1'b0;
         rx_accept_out <= 1'b0;
      end else begin
         irq_status_r <= (irq_status_read ? 3'h0 : irq_status_r) | irq_event_bits;
         irq_out <= |(((irq_status_read ? 3'h0 : irq_status_r) | irq_event_bits) & irq_mask_r);
         rx_accept_out <= do_write;
      end
   end
endmodule : can_rx_buffer_flags

// ==== can_rx_buffer_flags_chk.sv ====
// Concurrent checks on the ports of the receive flag block.
// Assumes it is bound to every instance of can_rx_buffer_flags by the statement at its foot.
`timescale 1ns/1ps
module can_rx_buffer_flags_chk #(
   parameter int NUM_BUFFERS = 32
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic rx_write_in,
   input wire logic [4:0] rx_buffer_in,
   input wire logic [10:0] msg_std_id_in,
   input wire logic [17:0] msg_ext_id_in,
   input wire logic msg_is_ext_in,
   input wire logic rx_accept_out,
   input wire logic irq_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (reset_in);
   sequence access_start;
      psel_in && penable_in && !pready_out;
   endsequence
   sequence flag_read;
      access_start ##0 (!pwrite_in && paddr_in >= 12'h00C && paddr_in <= 12'h018 && paddr_in[1:0] == 2'h0);
   endsequence
   chk_ready_one_wait: assert property (access_start |=> pready_out)
      else $error("ready not one cycle after access");
   chk_ready_one_cycle: assert property (pready_out |=> !pready_out)
      else $error("ready held too long");
   chk_err_with_ready: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   chk_unmapped_refused: assert property (access_start ##0 paddr_in > 12'h024 |=> pslverr_out && prdata_out == 32'h00000000)
      else $error("unmapped access not refused");
   chk_flag_upper_zero: assert property (flag_read |=> !pslverr_out && prdata_out[31:16] == 16'h0000)
      else $error("flag read malformed");
   chk_accept_cause: assert property (rx_accept_out |-> $past(rx_write_in))
      else $error("accept without receive write");
   chk_irq_has_cause: assert property ($rose(irq_out) |-> rx_accept_out || $past(pwrite_in) || $past(pwrite_in, 2))
      else $error("interrupt rose without event");
   chk_quiet_reset: assert property (disable iff (1'b0) reset_in |=> !rx_accept_out && !irq_out && !pready_out)
      else $error("outputs active in reset");
endmodule : can_rx_buffer_flags_chk
bind can_rx_buffer_flags can_rx_buffer_flags_chk #(.NUM_BUFFERS(NUM_BUFFERS)) i_can_rx_buffer_flags_chk (
   .sys_clk_in(sys_clk_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .rx_write_in(rx_write_in), .rx_buffer_in(rx_buffer_in),
   .msg_std_id_in(msg_std_id_in), .msg_ext_id_in(msg_ext_id_in), .msg_is_ext_in(msg_is_ext_in),
   .rx_accept_out(rx_accept_out), .irq_out(irq_out));

// ==== can_rx_buffer_flags_tb.sv ====
// Self-checking bench for the receive flag block: APB register tasks and receive-write pulses.
// Assumes the checker file is compiled beside it and binds itself.
`timescale 1ns/1ps
`include "can_rx_consts.svh"
module can_rx_buffer_flags_tb;
   logic sys_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, rx_write_in = 1'b0, msg_is_ext_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h00000000, prdata_out, rd;
   logic pready_out, pslverr_out, rx_accept_out, irq_out, err;
   logic [4:0] rx_buffer_in = 5'h00;
   logic [10:0] msg_std_id_in = 11'h000;
   logic [17:0] msg_ext_id_in = 18'h00000;
   int n_errors = 0;
   int tests_run = 0;
   always #50 sys_clk_in = ~sys_clk_in;
   can_rx_buffer_flags #(.NUM_BUFFERS(32)) i_can_rx_buffer_flags (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .rx_write_in(rx_write_in),
      .rx_buffer_in(rx_buffer_in), .msg_std_id_in(msg_std_id_in), .msg_ext_id_in(msg_ext_id_in),
      .msg_is_ext_in(msg_is_ext_in), .rx_accept_out(rx_accept_out), .irq_out(irq_out));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test
   // Request is held until pready is sampled high; data and error are taken at that same edge.
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int i;
      @(posedge sys_clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge sys_clk_in);
      penable_in <= 1'b1;
      for (i = 0; i < 20 && pready_out !== 1'b1; i++) begin
         @(posedge sys_clk_in);
      end
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      if (i == 20) begin
         n_errors++;
         finish_test();
      end
   endtask : apb
   task automatic rx(input logic [4:0] b, input logic ext, input logic [17:0] id, input logic acc);
      @(posedge sys_clk_in);
      rx_write_in <= 1'b1;
      rx_buffer_in <= b;
      msg_is_ext_in <= ext;
      msg_ext_id_in <= id;
      msg_std_id_in <= id[10:0];
      @(posedge sys_clk_in);
      rx_write_in <= 1'b0;
      #1 check({31'h00000000, rx_accept_out}, {31'h00000000, acc});
   endtask : rx
   initial begin
      repeat (16) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         apb(`OFS_FULL_LOW + 12'(4 * k), 1'b0, 32'h00000000);
         check(rd, 32'h00000000);
      end
      apb(`OFS_IRQ_MASK, 1'b1, 32'h00000007);
      apb(`OFS_EXT_MASK_LOW, 1'b1, 32'hFFFFA5C3);
      apb(`OFS_EXT_MASK_LOW, 1'b0, 32'h00000000);
      check(rd, 32'h0000A5C3);
      rx(5'h00, 1'b1, 18'h00001, 1'b0);
      check({31'h00000000, irq_out}, 32'h00000000);
      rx(5'h00, 1'b1, 18'h00004, 1'b1);
      check({31'h00000000, irq_out}, 32'h00000001);
      apb(`OFS_IRQ_STATUS, 1'b0, 32'h00000000);
      check(rd, 32'h00000005);
      apb(`OFS_IRQ_STATUS, 1'b0, 32'h00000000);
      check(rd, 32'h00000000);
      check({31'h00000000, irq_out}, 32'h00000000);
      apb(`OFS_IRQ_MASK, 1'b1, 32'h00000000);
      apb(`OFS_IRQ_MASK, 1'b0, 32'h00000000);
      check(rd, 32'h00000000);
      apb(`OFS_STD_MASK, 1'b1, 32'h00000020);
      rx(5'h0F, 1'b0, 18'h00001, 1'b0);
      rx(5'h0F, 1'b0, 18'h00002, 1'b1);
      apb(`OFS_STD_MASK, 1'b1, 32'h00000028);
      rx(5'h10, 1'b1, 18'h00004, 1'b0);
      rx(5'h10, 1'b0, 18'h00004, 1'b1);
      rx(5'h1F, 1'b0, 18'h00000, 1'b1);
      apb(`OFS_FULL_LOW, 1'b0, 32'h00000000);
      check(rd, 32'h00008001);
      apb(`OFS_FULL_HIGH, 1'b0, 32'h00000000);
      check(rd, 32'h00008001);
      rx(5'h10, 1'b0, 18'h00000, 1'b1);
      apb(`OFS_OVF_HIGH, 1'b0, 32'h00000000);
      check(rd, 32'h00000001);
      apb(`OFS_OVF_LOW, 1'b0, 32'h00000000);
      check(rd, 32'h00000000);
      check({31'h00000000, err}, 32'h00000000);
      check({31'h00000000, irq_out}, 32'h00000000);
      apb(`OFS_IRQ_STATUS, 1'b0, 32'h00000000);
      check(rd, 32'h00000007);
      apb(`OFS_FULL_LOW, 1'b1, 32'h0000FFFF);
      apb(`OFS_FULL_LOW, 1'b0, 32'h00000000);
      check(rd, 32'h00008001);
      apb(`OFS_FULL_LOW, 1'b1, 32'h0000FFFE);
      apb(`OFS_FULL_LOW, 1'b0, 32'h00000000);
      check(rd, 32'h00008000);
      apb(`OFS_OVF_HIGH, 1'b1, 32'h00000000);
      apb(`OFS_OVF_HIGH, 1'b0, 32'h00000000);
      check(rd, 32'h00000000);
      apb(12'h040, 1'b0, 32'h00000000);
      check({rd[30:0], err}, 32'h00000001);
      finish_test();
   end
endmodule : can_rx_buffer_flags_tb

// ==== can_rx_consts.svh ====
// Constants for the receive flag and mask block: register offsets, field positions, reset values.
// Included by bare name; holds definitions only.
`ifndef CAN_RX_CONSTS_SVH
`define CAN_RX_CONSTS_SVH
`define OFS_STD_MASK 12'h000
`define OFS_EXT_MASK_HIGH 12'h004
`define OFS_EXT_MASK_LOW 12'h008
`define OFS_FULL_LOW 12'h00C
`define OFS_FULL_HIGH 12'h010
`define OFS_OVF_LOW 12'h014
`define OFS_OVF_HIGH 12'h018
`define OFS_IRQ_STATUS 12'h01C
`define OFS_IRQ_MASK 12'h020
`define OFS_FILTER 12'h024
`define STD_MASK_POS 5
`define ID_TYPE_MODE_POS 3
`define EXT_HIGH_MASK_POS 0
`define FILTER_STD_POS 16
`define FILTER_EXT_POS 0
`define FILTER_FORMAT_POS 29
`define IRQ_FILL_POS 0
`define IRQ_OVF_POS 1
`define IRQ_MATCH_POS 2
`define FLAGS_RESET 16'h0000
`define MASK_RESET 16'h0000
`define CTRL_RESET 32'h00000000
`define IRQ_RESET 3'h0
`endif

// ==== can_rx_flag_bank.sv ====
// One bank of sticky per-buffer flags, set by receive logic and cleared by software.
// Assumes set and clear requests are synchronous to sys_clk_in.
`timescale 1ns/1ps
`include "can_rx_consts.svh"
module can_rx_flag_bank #(
   parameter int NUM_BUFFERS = 32
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic [NUM_BUFFERS-1:0] set_in,
   input wire logic [NUM_BUFFERS-1:0] clear_in,
   output logic [NUM_BUFFERS-1:0] flags_out
);
   // A set arriving in the same cycle as a clear wins, so no event is lost.
   genvar i;
   generate
      for (i = 0; i < NUM_BUFFERS; i++) begin : g_flag
         always_ff @(posedge sys_clk_in) begin
            if (reset_in) begin
               flags_out[i] <= 1'b0;
            end else if (set_in[i]) begin
               flags_out[i] <= 1'b1;
            end else if (clear_in[i]) begin
               flags_out[i] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule : can_rx_flag_bank

// ==== can_rx_id_filter.sv ====
// Masked identifier comparison of one received message against one filter.
// Assumes message identifier and format arrive with the buffer-write request.
`timescale 1ns/1ps
module can_rx_id_filter (
   input wire logic [10:0] msg_std_id_in,
   input wire logic [17:0] msg_ext_id_in,
   input wire logic msg_is_ext_in,
   input wire logic [10:0] filt_std_id_in,
   input wire logic [17:0] filt_ext_id_in,
   input wire logic filter_format_select_in,
   input wire logic [10:0] std_id_mask_bits_in,
   input wire logic [17:0] ext_id_mask_bits_in,
   input wire logic id_type_match_mode_in,
   output logic match_out
);
   wire std_equal;
   wire ext_equal;
   wire format_ok;
   assign std_equal = ((msg_std_id_in ^ filt_std_id_in) & std_id_mask_bits_in) == 11'h000;
   assign ext_equal = ((msg_ext_id_in ^ filt_ext_id_in) & ext_id_mask_bits_in) == 18'h00000;
   // A standard frame carries no extended bits, so only the standard part is compared for it.
   assign format_ok = !id_type_match_mode_in || (msg_is_ext_in == filter_format_select_in);
   assign match_out = format_ok && std_equal && (!msg_is_ext_in || ext_equal);
endmodule : can_rx_id_filter

// ==== can_rx_pkg.sv ====
// Types for the receive flag and mask block.
// Assumes nothing of its surroundings.
package can_rx_pkg;
   typedef enum logic [1:0] {bus_idle, bus_access} apb_phase_e;
   typedef logic [15:0] half_word_t;
endpackage : can_rx_pkg
